// File: rtl/nad_core.sv
// Nibble ALU datapath: arithmetic, logic, tests, rotate.
// Assumes the decoder presents operands in one cycle
// and writes back what res_o asks for.
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "nad_params.svh"
module nad_core (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  req_valid_i,
	input  nad_pkg::nad_req_t          req_i,
	output logic                       res_valid_o,
	output nad_pkg::nad_res_t          res_o,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [`NAD_ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic [31:0]                wb_dat_o,
	output logic                       wb_ack_o,
	output logic                       wb_err_o
);
	import nad_pkg::*;

	// Flag and control state
	logic [3:0] psw_q;
	logic [3:0] psw_d;
	logic       en_q;
	logic       pend_q;
	logic       pend_d;
	logic       null_q;
	logic [3:0] last_q;
	nad_res_t   res_q;
	nad_res_t   res_d;
	logic       rv_q;

	// Bus side strobes
	logic       psw_wr;
	logic       ctrl_wr;
	logic [3:0] wdata;

	// Decoded operation class
	nad_op_t    op;
	logic       is_arith;
	logic       is_logic;
	logic       is_bit;
	logic       is_cmp;
	logic       is_rot;
	logic       is_sub;
	logic       use_cin;
	logic       mem_side;

	// Issue qualifiers
	logic       go;
	logic       live;
	logic       nulled;

	// Datapath
	logic [3:0] opa;
	logic [3:0] opb;
	logic [3:0] sum;
	logic       cout;
	logic [3:0] lres;
	logic [3:0] rot;
	logic [3:0] masked;
	logic [3:0] val;
	logic       skip;
	logic       store;

	// Named flag views
	logic       f_dec;
	logic       f_zero;
	logic       f_carry;
	logic       f_hold;

	assign f_dec   = psw_q[`NAD_PSW_DEC];
	assign f_zero  = psw_q[`NAD_PSW_ZERO];
	assign f_carry = psw_q[`NAD_PSW_CARRY];
	assign f_hold  = psw_q[`NAD_PSW_HOLD];

	// Register bus slave
	nad_wb_slave u_wb (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.cyc_i    (wb_cyc_i),
		.stb_i    (wb_stb_i),
		.we_i     (wb_we_i),
		.adr_i    (wb_adr_i),
		.sel_i    (wb_sel_i),
		.dat_i    (wb_dat_i),
		.dat_o    (wb_dat_o),
		.ack_o    (wb_ack_o),
		.err_o    (wb_err_o),
		.psw_i    ({4'h0, psw_q}),
		.stat_i   ({2'b00, null_q, pend_q, last_q}),
		.ctrl_i   ({7'h0, en_q}),
		.wr_psw_o (psw_wr),
		.wr_ctrl_o(ctrl_wr),
		.wdata_o  (wdata)
	);

	// Operation classes
	assign op       = req_i.op;
	assign is_arith = (op == NAD_OP_ADD) | (op == NAD_OP_ADD_WITH_CARRY)
		| (op == NAD_OP_SUB) | (op == NAD_OP_SUBTRACT_WITH_BORROW);
	assign is_logic = (op == NAD_OP_OR) | (op == NAD_OP_AND) | (op == NAD_OP_XOR);
	assign is_bit   = (op == NAD_OP_BSET) | (op == NAD_OP_BCLR);
	assign is_cmp   = (op == NAD_OP_EQ) | (op == NAD_OP_NE)
		| (op == NAD_OP_GE) | (op == NAD_OP_LT);
	assign is_rot   = (op == NAD_OP_ROT);
	assign use_cin  = (op == NAD_OP_ADD_WITH_CARRY) | (op == NAD_OP_SUBTRACT_WITH_BORROW);
	assign is_sub   = (op == NAD_OP_SUB) | (op == NAD_OP_SUBTRACT_WITH_BORROW) | is_cmp;

	// Disabled block ignores requests; a pending skip eats one
	assign go     = req_valid_i & en_q;
	assign nulled = go & pend_q;
	assign live   = go & ~pend_q;

	// Immediate forms and compares work memory against immediate
	assign mem_side = req_i.imm_form | is_cmp;
	assign opa = mem_side ? req_i.mem : req_i.gen_reg;
	assign opb = mem_side ? req_i.imm : req_i.mem;

	// Compares always run binary so the digit fix cannot bend them
	nad_arith u_arith (
		.a_i   (~is_sub),
		.x_i   (opa),
		.y_i   (opb),
		.cin_i (use_cin & f_carry),
		.sub_i (is_sub),
		.dec_i (f_dec & is_arith),
		.sum_o (sum),
		.cout_o(cout)
	);

	// Bitwise results
	assign lres = (op == NAD_OP_OR) ? (opa | opb)
		: (op == NAD_OP_AND) ? (opa & opb) : (opa ^ opb);

	// Old carry enters at the top, bit 0 leaves to carry
	assign rot = {f_carry, req_i.gen_reg[3:1]};

	// Mask test on memory
	assign masked = req_i.mem & req_i.imm;

	// Skip decision, all four-bit compares
	always_comb begin
		case (op)
			NAD_OP_BSET: skip = (masked == req_i.imm);
			NAD_OP_BCLR: skip = (masked == 4'h0);
			NAD_OP_EQ:   skip = (sum == 4'h0);
			NAD_OP_NE:   skip = (sum != 4'h0);
			NAD_OP_GE:   skip = ~cout;
			NAD_OP_LT:   skip = cout;
			default:     skip = 1'b0;
		endcase
	end

	// Value presented for writeback
	assign val = is_arith ? sum : is_logic ? lres : is_rot ? rot : 4'h0;

	// Arithmetic store is blocked while hold is set
	assign store = live & (is_logic | is_rot | (is_arith & ~f_hold));

	// Result word for the decoder
	always_comb begin
		res_d        = '0;
		res_d.data   = val;
		res_d.wr_reg = store & ~req_i.imm_form & ~is_rot | store & is_rot;
		res_d.wr_mem = store & req_i.imm_form & ~is_rot;
		res_d.skip   = live & skip;
	end

	// Flag update: hardware effects win over a bus write
	always_comb begin
		psw_d = psw_wr ? wdata : psw_q;
		if (live & is_arith) begin // compares never reach this branch
			psw_d[`NAD_PSW_CARRY] = cout;
			if (sum != 4'h0) begin
				psw_d[`NAD_PSW_ZERO] = 1'b0;
			end else if (!f_hold) begin
				psw_d[`NAD_PSW_ZERO] = 1'b1;
			end else begin
				psw_d[`NAD_PSW_ZERO] = f_zero;
			end
		end
		if (live & is_rot) begin
			psw_d[`NAD_PSW_CARRY] = req_i.gen_reg[0];
		end
		if (live & is_bit) begin
			psw_d[`NAD_PSW_HOLD] = 1'b0;
		end
	end

	// Skip pending is consumed by the next accepted request
	assign pend_d = nulled ? 1'b0 : (live & skip) ? 1'b1 : pend_q;

	// Flags and control
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			psw_q  <= `NAD_PSW_RST;
			en_q   <= `NAD_CTRL_RST;
			pend_q <= 1'b0;
		end else begin
			psw_q  <= psw_d;
			pend_q <= pend_d;
			if (ctrl_wr) begin
				en_q <= wdata[`NAD_CTRL_EN];
			end
		end
	end

	// Registered answer, one cycle after the request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			res_q  <= '0;
			rv_q   <= 1'b0;
			null_q <= 1'b0;
			last_q <= 4'h0;
		end else begin
			rv_q  <= go;
			res_q <= live ? res_d : '0;
			if (go) begin
				null_q <= nulled;
				last_q <= live ? val : last_q;
			end
		end
	end

	assign res_valid_o = rv_q;
	assign res_o       = res_q;

	// Checks on the datapath
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// Helper views of the taken request
	logic [3:0] chk_add;
	logic [3:0] chk_dif;
	logic [3:0] chk_xor;
	logic       chk_c0;
	logic       chk_lt;
	assign chk_add = 4'(req_i.gen_reg + req_i.mem);
	assign chk_dif = 4'(req_i.mem - req_i.imm);
	assign chk_xor = req_i.mem ^ req_i.imm;
	assign chk_c0  = req_i.gen_reg[0];
	assign chk_lt  = req_i.mem < req_i.imm;

	property p_add_reg;
		live && op == NAD_OP_ADD && !req_i.imm_form && !f_hold && !f_dec
		|=> rv_q && res_q.wr_reg && !res_q.wr_mem && res_q.data == $past(chk_add);
	endproperty
	a_add_reg: assert property (p_add_reg) else $error("register add wrong");

	property p_sub_mem;
		live && op == NAD_OP_SUB && req_i.imm_form && !f_hold && !f_dec
		|=> res_q.wr_mem && !res_q.wr_reg && res_q.data == $past(chk_dif);
	endproperty
	a_sub_mem: assert property (p_sub_mem) else $error("memory subtract wrong");

	property p_xor_mem;
		live && op == NAD_OP_XOR && req_i.imm_form
		|=> res_q.wr_mem && res_q.data == $past(chk_xor);
	endproperty
	a_xor_mem: assert property (p_xor_mem) else $error("xor result wrong");

	property p_bit_hold;
		live && is_bit && !psw_wr |=> !f_hold && !res_q.wr_reg && !res_q.wr_mem;
	endproperty
	a_bit_hold: assert property (p_bit_hold) else $error("bit test left hold set");

	property p_cmp_carry;
		live && is_cmp && !psw_wr |=> f_carry == $past(f_carry) && !res_q.wr_mem;
	endproperty
	a_cmp_carry: assert property (p_cmp_carry) else $error("compare moved carry");

	property p_eq_skip;
		live && op == NAD_OP_EQ |=> res_q.skip == ($past(chk_dif) == 4'h0);
	endproperty
	a_eq_skip: assert property (p_eq_skip) else $error("equal skip wrong");

	property p_ge_skip;
		live && op == NAD_OP_GE |=> res_q.skip == !$past(chk_lt);
	endproperty
	a_ge_skip: assert property (p_ge_skip) else $error("not-less skip wrong");

	property p_lt_skip;
		live && op == NAD_OP_LT |=> res_q.skip == $past(chk_lt);
	endproperty
	a_lt_skip: assert property (p_lt_skip) else $error("below skip wrong");

	property p_logic_flags;
		live && is_logic && !psw_wr |=> $stable(psw_q);
	endproperty
	a_logic_flags: assert property (p_logic_flags) else $error("logic op moved flags");

	property p_hold_block;
		live && is_arith && f_hold |=> rv_q && !res_q.wr_reg && !res_q.wr_mem;
	endproperty
	a_hold_block: assert property (p_hold_block) else $error("held result stored");

	property p_rot;
		live && is_rot && !psw_wr
		|=> f_carry == $past(chk_c0) && res_q.data[3] == $past(f_carry) && res_q.wr_reg;
	endproperty
	a_rot: assert property (p_rot) else $error("rotate wrong");

	property p_dec_digit;
		live && op == NAD_OP_ADD && f_dec && !f_hold && !req_i.imm_form
		&& req_i.gen_reg <= 4'h9 && req_i.mem <= 4'h9 |=> res_q.data <= 4'h9;
	endproperty
	a_dec_digit: assert property (p_dec_digit) else $error("decimal digit out of range");

	sequence s_skip_met;
		live && skip;
	endsequence
	sequence s_null_issue;
		nulled && !psw_wr;
	endsequence
	property p_skip_pend;
		s_skip_met |=> pend_q && res_q.skip;
	endproperty
	a_skip_pend: assert property (p_skip_pend) else $error("met skip not held pending");

	// The nulled request may come any number of cycles after the skip
	property p_skip_null;
		s_null_issue |=> rv_q && res_q == '0 && $stable(psw_q) && !pend_q;
	endproperty
	a_skip_null: assert property (p_skip_null) else $error("skipped op not nulled");
endmodule

// File: rtl/nad_params.svh
// Constants of the nibble ALU datapath.
// Assumes inclusion by bare name from rtl/.
`ifndef NAD_PARAMS_SVH
`define NAD_PARAMS_SVH
`define NAD_NIB_W 4
`define NAD_ADR_W 8
`define NAD_OFF_PSW 8'h00
`define NAD_OFF_STAT 8'h04
`define NAD_OFF_CTRL 8'h08
`define NAD_PSW_DEC 0
`define NAD_PSW_ZERO 1
`define NAD_PSW_CARRY 2
`define NAD_PSW_HOLD 3
`define NAD_PSW_RST 4'h0
`define NAD_CTRL_EN 0
`define NAD_CTRL_RST 1'b1
`define NAD_STAT_PEND 4
`define NAD_STAT_NULL 5
`define NAD_DEC_MAX 5'h09
`define NAD_DEC_ADJ 4'h6
`endif

// File: rtl/nad_pkg.sv
// Types shared by the nibble ALU datapath files.
// Assumes nad_params.svh is on the include path.
`include "nad_params.svh"
package nad_pkg;
	typedef enum logic [3:0] {
		NAD_OP_NOP  = 4'h0,
		NAD_OP_ADD  = 4'h1,
		NAD_OP_ADD_WITH_CARRY = 4'h2,
		NAD_OP_SUB  = 4'h3,
		NAD_OP_SUBTRACT_WITH_BORROW = 4'h4,
		NAD_OP_OR   = 4'h5,
		NAD_OP_AND  = 4'h6,
		NAD_OP_XOR  = 4'h7,
		NAD_OP_BSET = 4'h8,
		NAD_OP_BCLR = 4'h9,
		NAD_OP_EQ   = 4'ha,
		NAD_OP_NE   = 4'hb,
		NAD_OP_GE   = 4'hc,
		NAD_OP_LT   = 4'hd,
		NAD_OP_ROT  = 4'he
	} nad_op_t;
	typedef struct packed {
		nad_op_t    op;
		logic       imm_form;
		logic [3:0] imm;
		logic [3:0] gen_reg;
		logic [3:0] mem;
	} nad_req_t;
	typedef struct packed {
		logic       wr_reg;
		logic       wr_mem;
		logic [3:0] data;
		logic       skip;
	} nad_res_t;
	typedef enum logic [1:0] {
		NAD_WB_IDLE = 2'b00,
		NAD_WB_ACK  = 2'b01
	} nad_wb_st_t;
	// Address match against one register offset
	function automatic logic nad_hit(input logic [`NAD_ADR_W-1:0] adr, input logic [`NAD_ADR_W-1:0] off);
		return adr == off;
	endfunction
endpackage

// File: rtl/nad_arith.sv
// Nibble adder/subtractor with one-digit decimal adjust.
// Assumes operands are already selected by the caller.
`timescale 1ns/1ps
`include "nad_params.svh"
module nad_arith (
	input  wire logic       a_i,
	input  wire logic [3:0] x_i,
	input  wire logic [3:0] y_i,
	input  wire logic       cin_i,
	input  wire logic       sub_i,
	input  wire logic       dec_i,
	output logic [3:0]      sum_o,
	output logic            cout_o
);
	import nad_pkg::*;
	logic [4:0] bin;
	logic       fix;
	// Five-bit result keeps the carry or borrow in bit 4
	assign bin = sub_i ? 5'({1'b0, x_i} - {1'b0, y_i} - {4'h0, cin_i})
		: 5'({1'b0, x_i} + {1'b0, y_i} + {4'h0, cin_i});
	// Decimal fix: sum above nine, or a borrow on subtract
	assign fix = dec_i & (sub_i ? bin[4] : (bin > `NAD_DEC_MAX));
	assign sum_o = !fix ? bin[3:0] : sub_i ? 4'(bin[3:0] - `NAD_DEC_ADJ) : 4'(bin[3:0] + `NAD_DEC_ADJ);
	assign cout_o = bin[4] | (fix & ~sub_i & a_i);
endmodule

// File: rtl/nad_wb_slave.sv
// Classic Wishbone slave for the three ALU registers.
// Assumes one request at a time; answers one cycle later.
`timescale 1ns/1ps
`include "nad_params.svh"
module nad_wb_slave (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  cyc_i,
	input  wire logic                  stb_i,
	input  wire logic                  we_i,
	input  wire logic [`NAD_ADR_W-1:0] adr_i,
	input  wire logic [3:0]            sel_i,
	input  wire logic [31:0]           dat_i,
	output logic [31:0]                dat_o,
	output logic                       ack_o,
	output logic                       err_o,
	input  wire logic [7:0]            psw_i,
	input  wire logic [7:0]            stat_i,
	input  wire logic [7:0]            ctrl_i,
	output logic                       wr_psw_o,
	output logic                       wr_ctrl_o,
	output logic [3:0]                 wdata_o
);
	import nad_pkg::*;
	nad_wb_st_t  st_q;
	logic        map_q;
	logic [31:0] dat_q;
	logic        h_psw;
	logic        h_stat;
	logic        h_ctrl;
	logic        wr_ok;
	// Address decode
	assign h_psw  = nad_hit(adr_i, `NAD_OFF_PSW);
	assign h_stat = nad_hit(adr_i, `NAD_OFF_STAT);
	assign h_ctrl = nad_hit(adr_i, `NAD_OFF_CTRL);
	// Writes land on the edge where the master sees ack
	assign wr_ok     = (st_q == NAD_WB_ACK) & map_q & we_i & sel_i[0];
	assign wr_psw_o  = wr_ok & h_psw;
	assign wr_ctrl_o = wr_ok & h_ctrl;
	assign wdata_o   = dat_i[3:0];
	assign ack_o     = (st_q == NAD_WB_ACK) & map_q;
	assign err_o     = (st_q == NAD_WB_ACK) & ~map_q;
	assign dat_o     = dat_q;
	// One-cycle answer; ack drops on the following cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q  <= NAD_WB_IDLE;
			map_q <= 1'b0;
			dat_q <= 32'h0;
		end else begin
			case (st_q)
				NAD_WB_IDLE: begin
					if (cyc_i & stb_i) begin
						st_q  <= NAD_WB_ACK;
						map_q <= h_psw | h_stat | h_ctrl;
						dat_q <= {24'h0, h_psw ? psw_i : h_stat ? stat_i : h_ctrl ? ctrl_i : 8'h0};
					end
				end
				default: begin
					st_q <= NAD_WB_IDLE;
				end
			endcase
		end
	end
endmodule

// File: verif/nad_partner.sv
// Behavioural CPU side: decoder issue, general register and one memory nibble.
// Assumes the bench loads the operands first and then names the operation.
`timescale 1ns/1ps
module nad_partner (
	input  wire logic         clk_i,
	input  wire logic         load_i,
	input  wire logic         go_i,
	input  nad_pkg::nad_req_t cmd_i,
	input  wire logic         res_valid_i,
	input  nad_pkg::nad_res_t res_i,
	output logic              req_valid_o,
	output nad_pkg::nad_req_t req_o
);
	import nad_pkg::*;
	logic [3:0] reg_q;
	logic [3:0] mem_q;

	// One request a cycle; idle fields toggle so a stale operand is never reused
	always_ff @(posedge clk_i) begin
		req_valid_o <= go_i;
		req_o       <= go_i ? {cmd_i.op, cmd_i.imm_form, cmd_i.imm, reg_q, mem_q} : ~req_o;
	end

	// Operand load, then write-back wherever the result asks for it
	always_ff @(posedge clk_i) begin
		if (load_i) begin
			reg_q <= cmd_i.gen_reg;
			mem_q <= cmd_i.mem;
		end else if (res_valid_i) begin
			if (res_i.wr_reg)
				reg_q <= res_i.data;
			if (res_i.wr_mem)
				mem_q <= res_i.data;
		end
	end
endmodule

// File: verif/test_nibble_alu_datapath.sv
// Self-checking bench for the nibble ALU core and its flag registers.
// Assumes flags at offset 00 (dec, zero, carry, hold) and enable at 08.
`timescale 1ns/1ps
module test_nibble_alu_datapath;
	import nad_pkg::*;
	typedef struct packed { logic [3:0] op, f, p, a, b, n, d, w, ep; } nad_tv_t;
	typedef struct packed { logic [3:0] op, p, b, n, s, ep; } nad_sv_t;
	logic clk_i, rst_i, cyc, stb, we, load, go, req_valid, res_valid_o, wb_ack_o, wb_err_o, re, seen;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat, rd, wb_dat_o;
	nad_req_t    cmd, req;
	nad_res_t    res_o, res;
	int          errors, cmp_count;
	// Rows: op, imm form, flags before, reg, mem, imm, data, stored, flags after
	logic [35:0] tv [22] = '{36'h100340710, 36'h110098114, 36'h204590f10, 36'h2140f0016, 36'h300350e14,
		36'h310072510, 36'h404830410, 36'h414000f14, 36'h504a50f14, 36'h6140c6414, 36'h7049f0614,
		36'he04300914, 36'he00200110, 36'h31a03300a, 36'h31a052308, 36'h318033008, 36'h108f1000c,
		36'h101850315, 36'h301250715, 36'h10985030d, 36'h608350118, 36'h71409f614};
	// Rows: op, flags before, mem, imm or mask, skip, flags after
	logic [23:0] sv [12] = '{24'ha45514, 24'ha45604, 24'hb45614, 24'hb43304, 24'hc47714, 24'hc42304,
		24'hd42314, 24'hd43204, 24'h88ba10, 24'h849a04, 24'h985a10, 24'h947a04};

	nad_partner nad_partner_inst (.clk_i(clk_i), .load_i(load), .go_i(go), .cmd_i(cmd),
		.res_valid_i(res_valid_o), .res_i(res_o), .req_valid_o(req_valid), .req_o(req));
	nad_core nad_core_inst (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid), .req_i(req),
		.res_valid_o(res_valid_o), .res_o(res_o), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.wb_err_o(wb_err_o));

	// Free-running 250 MHz clock
	always #2 clk_i = ~clk_i;

	task ck(input logic [3:0] g, input logic [3:0] e, input string m);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask

	task hang();
		errors++;
		$display("CHECK FAILED %0t no answer", $time);
		test_done();
	endtask

	// Classic single Wishbone cycle; the answer is taken at the edge that shows ack or err
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		sel <= 4'hf;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 16);
		if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1)
			hang();
		rd = wb_dat_o;
		re = wb_err_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		sel <= 4'h0;
	endtask

	// Load operands, issue one request, catch the single result pulse
	task alu(input logic [3:0] op, f, n, a, b, input bit quiet);
		int k;
		k = 0;
		@(posedge clk_i);
		load <= 1'b1;
		cmd  <= {op, f[0], n, a, b};
		@(posedge clk_i);
		load <= 1'b0;
		go   <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		do begin
			@(posedge clk_i);
			k++;
		end while (res_valid_o !== 1'b1 && k < 6);
		seen = (res_valid_o === 1'b1);
		res  = res_o;
		if (!seen && !quiet)
			hang();
	endtask

	task t_reset();
		wb(1'b0, 8'h00, 32'h0);
		ck(rd[3:0], 4'h0, "flags after reset");
		wb(1'b0, 8'h08, 32'h0);
		ck(rd[3:0], 4'h1, "enable after reset");
		wb(1'b1, 8'h0c, 32'h5);
		ck({3'h0, re}, 4'h1, "unmapped address not refused");
	endtask

	// Arithmetic, logic and rotate; the carry-in ops run with carry set only
	task t_arith();
		nad_tv_t v;
		foreach (tv[i]) begin
			v = nad_tv_t'(tv[i]);
			wb(1'b1, 8'h00, {28'h0, v.p});
			alu(v.op, v.f, v.n, v.a, v.b, 1'b0);
			ck(res.data, v.d, "result");
			ck({2'h0, res.wr_reg, res.wr_mem}, {2'h0, v.w[0] & ~v.f[0], v.w[0] & v.f[0]}, "target");
			wb(1'b0, 8'h00, 32'h0);
			ck(rd[3:0], v.ep, "flags after op");
		end
	endtask

	// Tests and compares, each followed by an add that a met skip must null
	task t_skip();
		nad_sv_t u;
		foreach (sv[i]) begin
			u = nad_sv_t'(sv[i]);
			wb(1'b1, 8'h00, {28'h0, u.p});
			alu(u.op, 4'h1, u.n, 4'h0, u.b, 1'b0);
			ck({1'b0, res.wr_reg, res.wr_mem, res.skip}, {3'h0, u.s[0]}, "skip");
			wb(1'b0, 8'h00, 32'h0);
			ck(rd[3:0], u.ep, "flags after test");
			alu(4'h1, 4'h0, 4'h0, 4'h1, 4'h1, 1'b0);
			ck(res.data, u.s[0] ? 4'h0 : 4'h2, "follow-up data");
			ck({2'h0, res.wr_reg, res.skip}, {2'h0, ~u.s[0], 1'b0}, "follow-up store");
		end
	endtask

	task t_enable();
		wb(1'b1, 8'h08, 32'h0);
		alu(4'h1, 4'h0, 4'h0, 4'h1, 4'h1, 1'b1);
		ck({3'h0, seen}, 4'h0, "request taken while disabled");
		wb(1'b1, 8'h08, 32'h1);
		alu(4'h1, 4'h0, 4'h0, 4'h2, 4'h3, 1'b0);
		ck(res.data, 4'h5, "no result after enable");
	endtask

	// Reset in mid-run must clear the flags and a pending skip
	task t_rerun();
		wb(1'b1, 8'h00, 32'hf);
		alu(4'ha, 4'h1, 4'h5, 4'h0, 4'h5, 1'b0);
		wb(1'b0, 8'h04, 32'h0);
		ck(rd[7:4], 4'h1, "met skip not pending");
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 8'h00, 32'h0);
		ck(rd[3:0], 4'h0, "flags after mid-run reset");
		wb(1'b0, 8'h04, 32'h0);
		ck(rd[7:4], 4'h0, "status after mid-run reset");
		alu(4'h1, 4'h0, 4'h0, 4'h2, 4'h3, 1'b0);
		ck({res.data[2:0], res.wr_reg}, 4'hb, "skip survived reset");
	endtask

	task test_done();
		$display("errors=%0d cmp_count=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Reset for 16 cycles, then the scenarios in turn
	initial begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		{cyc, stb, we, load, go} = 5'h0;
		sel = 4'h0;
		adr = 8'h00;
		dat = 32'h0;
		cmd = '0;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_arith();
		t_skip();
		t_enable();
		t_rerun();
		test_done();
	end
endmodule
